// file: design/mlsc_pkg.sv
package mlsc_pkg;
    // register offsets, canonical and mirrored
    localparam logic [7:0] OFS_STATUS      = 8'h02;
    localparam logic [7:0] OFS_STATUS_ALT  = 8'h34;
    localparam logic [7:0] OFS_CONFIG      = 8'h03;
    localparam logic [7:0] OFS_CONFIG_ALT  = 8'h09;
    localparam logic [7:0] OFS_RATE        = 8'h04;
    localparam logic [7:0] OFS_RATE_ALT    = 8'h0a;
    localparam logic [7:0] OFS_LOC_HI      = 8'h05;
    localparam logic [7:0] OFS_LOC_HI_ALT  = 8'h0b;
    localparam logic [7:0] OFS_LOC_LO      = 8'h06;
    localparam logic [7:0] OFS_LOC_LO_ALT  = 8'h0c;
    localparam logic [7:0] OFS_REM_HI      = 8'h07;
    localparam logic [7:0] OFS_REM_HI_ALT  = 8'h0d;
    localparam logic [7:0] OFS_REM_LO      = 8'h08;
    localparam logic [7:0] OFS_REM_LO_ALT  = 8'h0e;
    localparam logic [7:0] OFS_ONE_SHOT    = 8'h0f;
    localparam logic [7:0] OFS_REM_HI_FR   = 8'h13;
    localparam logic [7:0] OFS_REM_LO_FR   = 8'h14;
    localparam logic [7:0] OFS_REM_CRIT    = 8'h19;
    localparam logic [7:0] OFS_FAULT       = 8'h1b;
    localparam logic [7:0] OFS_LOC_CRIT    = 8'h20;
    localparam logic [7:0] OFS_HYST        = 8'h21;

    // reset values
    localparam logic [7:0] RST_CONFIG      = 8'h00;
    localparam logic [7:0] RST_RATE        = 8'h06;
    localparam logic [7:0] RST_HI_LIMIT    = 8'h55;
    localparam logic [7:0] RST_LO_LIMIT    = 8'h80;
    localparam logic [7:0] RST_FRAC        = 8'h00;
    localparam logic [7:0] RST_CRIT        = 8'h64;
    localparam logic [7:0] RST_HYST        = 8'h0a;
    localparam logic [7:0] READ_ZERO       = 8'h00;

    // writable bit masks, and the fault register's one defined bit
    localparam logic [7:0] MSK_CONFIG      = 8'hf6;
    localparam logic [7:0] MSK_RATE        = 8'h07;
    localparam logic [7:0] MSK_FRAC        = 8'he0;
    localparam logic [7:0] MSK_HYST        = 8'h7f;
    localparam logic [7:0] MSK_FAULT       = 8'h02;

    // configuration bit positions
    localparam int CFG_MASK_ALL    = 7;
    localparam int CFG_TEMP_HALT   = 6;
    localparam int CFG_COMP_MODE   = 5;
    localparam int CFG_SERIES_OFF  = 4;
    localparam int CFG_VOLT_HALT   = 2;
    localparam int CFG_AVG_OFF     = 1;

    // status and fault bit positions
    localparam int ST_BUSY  = 7;
    localparam int ST_PEAK  = 6;
    localparam int ST_HIGH  = 4;
    localparam int ST_LOW   = 3;
    localparam int ST_FAULT = 2;
    localparam int ST_CRIT  = 1;
    localparam int FLT_REM  = 1;

    // conversion pacing: fastest rate is one update per tick
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_MS       = 125;
    localparam int TICK_CYCLES   = TICK_MS * 1000000 / CLK_PERIOD_NS;
    localparam logic [7:0] SLOWEST_TICKS = 8'h80;
endpackage

// file: design/mlsc_regs.sv
`timescale 1ns/1ps
// Behaviour
// - summary bits clear after channel status cleared
// - busy bit shows converting, never drives pins
// - peak bit follows live spike detector
// - high bit and alert on at-or-above high
// - low bit and interrupt-mode alert on low violation
// - fault bit and interrupt-mode alert on diode fault
// - crit bit and overtemp output, live
// - mask-all silences alert in interrupt mode
// - temperature halt, convert on one-shot or on the config write that releases the halt
// - config bit five selects comparator mode
// - config bit four disables series correction
// - voltage halt, convert on one-shot only
// - averaging-off forces 1x temperature averaging
// - mirrored addresses share one storage
// - three-bit update rate, reset 4 per second
// - limit formats and reset values
// - low violation means at-or-below low limit
// - new limits apply at next conversion
// - one-shot starts halted groups, reads zero
// - overtemp unmaskable, crit reset 100 degrees
// - overtemp releases below crit minus hysteresis
// - remote fault bit, cleared on read
module mlsc_regs
    import mlsc_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
) (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    // register port from the serial front end
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // converter results and live conditions
    input  wire logic       conv_busy,
    input  wire logic       spike_live,
    input  wire logic       temp_done,
    input  wire logic [7:0] local_int,
    input  wire logic [7:0] local_frac,
    input  wire logic [7:0] remote_int,
    input  wire logic [7:0] remote_frac,
    input  wire logic       remote_channel_fault,
    input  wire logic       volt_done,
    input  wire logic       volt_high,
    input  wire logic       volt_low,
    input  wire logic       volt_crit,
    // per-channel status registers reporting a read or clear
    input  wire logic       high_status_cleared,
    input  wire logic       low_status_cleared,
    // converter control
    output logic            temp_start,
    output logic            volt_start,
    output logic            series_r_correction_off,
    output logic            adaptive_averaging_off,
    output logic      [2:0] update_rate_code,
    // open-drain pins, enable high while pulling low
    output logic            alert_out_n,
    output logic            alert_out_n_oe,
    output logic            overtemp_out_n,
    output logic            overtemp_out_n_oe
);

    logic [7:0] config_q;
    logic [7:0] rate_q;
    logic [7:0] loc_hi_q, loc_lo_q, loc_crit_q;
    logic [7:0] rem_hi_q, rem_lo_q, rem_crit_q;
    logic [7:0] rem_hi_fr_q, rem_lo_fr_q;
    logic [7:0] hyst_q;
    logic [7:0] fault_q;
    logic       high_q, low_q, flt_sum_q;
    logic       loc_crit_st_q, rem_crit_st_q;
    logic       live_high_q;

    // read data, pacing counters and start pulses
    logic [7:0] rdata_q;
    logic [31:0] tick_cnt_q;
    logic [7:0]  per_cnt_q;
    logic        temp_start_q, volt_start_q;

    // map a mirrored address to its canonical offset
    function automatic logic [7:0] canon(input logic [7:0] a);
        unique case (a)
            OFS_STATUS_ALT: canon = OFS_STATUS;
            OFS_CONFIG_ALT: canon = OFS_CONFIG;
            OFS_RATE_ALT:   canon = OFS_RATE;
            OFS_LOC_HI_ALT: canon = OFS_LOC_HI;
            OFS_LOC_LO_ALT: canon = OFS_LOC_LO;
            OFS_REM_HI_ALT: canon = OFS_REM_HI;
            OFS_REM_LO_ALT: canon = OFS_REM_LO;
            default:        canon = a;
        endcase
    endfunction

    // integer byte plus top three fraction bits as one signed value
    function automatic logic signed [11:0] fix(input logic [7:0] i, input logic [7:0] f);
        fix = {i[7], i, f[7:5]};
    endfunction

    // ticks between updates: 128 at code 0 down to 1 at code 7
    function automatic logic [7:0] rate_ticks(input logic [2:0] c);
        rate_ticks = SLOWEST_TICKS >> c;
    endfunction

    logic [7:0] wa;
    logic       wr_cfg, wr_os;
    logic       temp_halt, volt_halt, comp_mode, mask_all;

    assign wa        = canon(reg_addr);
    assign wr_cfg    = reg_wr && (wa == OFS_CONFIG);
    assign wr_os     = reg_wr && (wa == OFS_ONE_SHOT);
    assign temp_halt = config_q[CFG_TEMP_HALT];
    assign volt_halt = config_q[CFG_VOLT_HALT];
    assign comp_mode = config_q[CFG_COMP_MODE];
    assign mask_all  = config_q[CFG_MASK_ALL];

    // configuration and rate; only defined bits are stored
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            config_q <= RST_CONFIG;
            rate_q   <= RST_RATE;
        end else if (reg_wr) begin
            if (wa == OFS_CONFIG) begin
                config_q <= reg_wdata & MSK_CONFIG;
            end
            if (wa == OFS_RATE) begin
                rate_q <= reg_wdata & MSK_RATE;
            end
        end
    end

    // limit registers; they feed only the compare done at conversion end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            loc_hi_q    <= RST_HI_LIMIT;
            loc_lo_q    <= RST_LO_LIMIT;
            rem_hi_q    <= RST_HI_LIMIT;
            rem_lo_q    <= RST_LO_LIMIT;
            rem_hi_fr_q <= RST_FRAC;
            rem_lo_fr_q <= RST_FRAC;
            loc_crit_q  <= RST_CRIT;
            rem_crit_q  <= RST_CRIT;
            hyst_q      <= RST_HYST;
        end else if (reg_wr) begin
            unique case (wa)
                OFS_LOC_HI:    loc_hi_q    <= reg_wdata;
                OFS_LOC_LO:    loc_lo_q    <= reg_wdata;
                OFS_REM_HI:    rem_hi_q    <= reg_wdata;
                OFS_REM_LO:    rem_lo_q    <= reg_wdata;
                OFS_REM_HI_FR: rem_hi_fr_q <= reg_wdata & MSK_FRAC;
                OFS_REM_LO_FR: rem_lo_fr_q <= reg_wdata & MSK_FRAC;
                OFS_LOC_CRIT:  loc_crit_q  <= reg_wdata;
                OFS_REM_CRIT:  rem_crit_q  <= reg_wdata;
                OFS_HYST:      hyst_q      <= reg_wdata & MSK_HYST;
                default:       ;
            endcase
        end
    end

    // conversion pacing: a tick every 125 ms, updates every 2^(7-code) ticks;
    // the slow rates need long counts, so TICK_LEN can be shortened in sim
    logic tick;
    logic period_end;

    assign tick       = (tick_cnt_q == TICK_LEN - 1);
    assign period_end = tick && (per_cnt_q >= rate_ticks(rate_q[2:0]) - 8'h01);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tick_cnt_q <= '0;
            per_cnt_q  <= '0;
        end else if (tick) begin
            tick_cnt_q <= '0;
            per_cnt_q  <= period_end ? 8'h00 : per_cnt_q + 8'h01;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'd1;
        end
    end

    // start pulses; a halted group runs only on one-shot, and releasing
    // the temperature halt starts a conversion at once
    logic temp_release;
    assign temp_release = wr_cfg && temp_halt && !reg_wdata[CFG_TEMP_HALT];

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            temp_start_q <= 1'b0;
            volt_start_q <= 1'b0;
        end else begin
            temp_start_q <= (!temp_halt && period_end)
                         || (temp_halt && wr_os)
                         || temp_release;
            volt_start_q <= (!volt_halt && period_end)
                         || (volt_halt && wr_os);
        end
    end
    assign temp_start = temp_start_q;
    assign volt_start = volt_start_q;

    // converter control straight from configuration
    assign series_r_correction_off = config_q[CFG_SERIES_OFF];
    assign adaptive_averaging_off  = config_q[CFG_AVG_OFF];
    assign update_rate_code        = rate_q[2:0];

    // limit compares on fresh results; a faulted remote reading is not compared
    logic signed [11:0] loc_t, rem_t;
    logic loc_hi_hit, loc_lo_hit, rem_hi_hit, rem_lo_hit;
    logic temp_hi_evt, temp_lo_evt, flt_evt;

    assign loc_t       = fix(local_int, local_frac);
    assign rem_t       = fix(remote_int, remote_frac);
    assign loc_hi_hit  = loc_t >= fix(loc_hi_q, RST_FRAC);
    assign loc_lo_hit  = loc_t <= fix(loc_lo_q, RST_FRAC);
    assign rem_hi_hit  = !remote_channel_fault && (rem_t >= fix(rem_hi_q, rem_hi_fr_q));
    assign rem_lo_hit  = !remote_channel_fault && (rem_t <= fix(rem_lo_q, rem_lo_fr_q));
    assign temp_hi_evt = temp_done && (loc_hi_hit || rem_hi_hit);
    assign temp_lo_evt = temp_done && (loc_lo_hit || rem_lo_hit);
    assign flt_evt     = temp_done && remote_channel_fault;

    // crit thresholds with hysteresis, widened so the subtraction cannot wrap
    logic signed [11:0] loc_set, loc_rel, rem_set, rem_rel, hyst_w;

    // hysteresis has no sign bit, so the release point never rises above the set point
    assign hyst_w  = fix(hyst_q, RST_FRAC);
    assign loc_set = fix(loc_crit_q, RST_FRAC);
    assign rem_set = fix(rem_crit_q, RST_FRAC);
    assign loc_rel = loc_set - hyst_w;
    assign rem_rel = rem_set - hyst_w;

    // crit state per channel: set at or above limit, released below limit
    // minus hysteresis or, for the remote channel, on a fault; otherwise held
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            loc_crit_st_q <= 1'b0;
            rem_crit_st_q <= 1'b0;
        end else if (temp_done) begin
            if (loc_t >= loc_set) begin
                loc_crit_st_q <= 1'b1;
            end else if (loc_t < loc_rel) begin
                loc_crit_st_q <= 1'b0;
            end
            if (!remote_channel_fault && rem_t >= rem_set) begin
                rem_crit_st_q <= 1'b1;
            end else if (remote_channel_fault || rem_t < rem_rel) begin
                rem_crit_st_q <= 1'b0;
            end
        end
    end

    // sticky summary bits; a new event wins over a clear in the same cycle
    logic fault_rd;
    assign fault_rd = reg_rd && (wa == OFS_FAULT);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            high_q    <= 1'b0;
            low_q     <= 1'b0;
            flt_sum_q <= 1'b0;
            fault_q   <= READ_ZERO;
        end else begin
            if (temp_hi_evt || (volt_done && volt_high)) begin
                high_q <= 1'b1;
            end else if (high_status_cleared) begin
                high_q <= 1'b0;
            end
            if (temp_lo_evt || (volt_done && volt_low)) begin
                low_q <= 1'b1;
            end else if (low_status_cleared) begin
                low_q <= 1'b0;
            end
            if (flt_evt) begin
                flt_sum_q <= 1'b1;
            end else if (fault_rd) begin
                flt_sum_q <= 1'b0;
            end
            if (flt_evt) begin
                fault_q <= MSK_FAULT;
            end else if (fault_rd) begin
                fault_q <= READ_ZERO;
            end
        end
    end

    // live high condition for comparator mode, refreshed per conversion
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            live_high_q <= 1'b0;
        end else if (temp_done) begin
            live_high_q <= loc_hi_hit || rem_hi_hit;
        end
    end

    // status byte; busy is shown but feeds neither pin
    logic       crit_live;
    logic [7:0] status_v;
    assign crit_live = loc_crit_st_q || rem_crit_st_q || volt_crit;

    always_comb begin
        status_v           = READ_ZERO;
        status_v[ST_BUSY]  = conv_busy;
        status_v[ST_PEAK]  = spike_live;
        status_v[ST_HIGH]  = high_q;
        status_v[ST_LOW]   = low_q;
        status_v[ST_FAULT] = flt_sum_q;
        status_v[ST_CRIT]  = crit_live;
    end

    // read mux; one-shot and unmapped offsets read zero
    logic [7:0] rd_v;

    always_comb begin
        unique case (wa)
            OFS_STATUS:    rd_v = status_v;
            OFS_CONFIG:    rd_v = config_q;
            OFS_RATE:      rd_v = rate_q;
            OFS_LOC_HI:    rd_v = loc_hi_q;
            OFS_LOC_LO:    rd_v = loc_lo_q;
            OFS_REM_HI:    rd_v = rem_hi_q;
            OFS_REM_LO:    rd_v = rem_lo_q;
            OFS_REM_HI_FR: rd_v = rem_hi_fr_q;
            OFS_REM_LO_FR: rd_v = rem_lo_fr_q;
            OFS_REM_CRIT:  rd_v = rem_crit_q;
            OFS_FAULT:     rd_v = fault_q;
            OFS_LOC_CRIT:  rd_v = loc_crit_q;
            OFS_HYST:      rd_v = hyst_q;
            default:       rd_v = READ_ZERO;
        endcase
    end

    // read data registered on the read strobe and held until the next one
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdata_q <= READ_ZERO;
        end else if (reg_rd) begin
            rdata_q <= rd_v;
        end
    end
    assign reg_rdata = rdata_q;

    // alert: interrupt mode follows sticky bits under mask-all, comparator
    // mode follows the live high and peak conditions and ignores the mask
    logic alert_q;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            alert_q <= 1'b0;
        end else if (comp_mode) begin
            alert_q <= live_high_q || spike_live || (volt_high && !volt_done);
        end else begin
            alert_q <= !mask_all && (high_q || low_q || flt_sum_q);
        end
    end
    assign alert_out_n    = !alert_q;
    assign alert_out_n_oe = alert_q;

    // overtemp pin: no mask reaches it, it drops with the crit state
    logic ot_q;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ot_q <= 1'b0;
        end else begin
            ot_q <= crit_live;
        end
    end
    assign overtemp_out_n    = !ot_q;
    assign overtemp_out_n_oe = ot_q;

endmodule

// file: sim/mlsc_check_assertions.sv
`timescale 1ns/1ps
module mlsc_check
    import mlsc_pkg::*;
(
    // clock and reset
    input wire logic       clock,
    input wire logic       rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // live conditions
    input wire logic       conv_busy,
    input wire logic       spike_live,
    input wire logic       temp_done,
    input wire logic       volt_crit,
    // converter control and pins
    input wire logic       temp_start,
    input wire logic       volt_start,
    input wire logic       series_r_correction_off,
    input wire logic       adaptive_averaging_off,
    input wire logic [2:0] update_rate_code,
    input wire logic       alert_out_n,
    input wire logic       alert_out_n_oe,
    input wire logic       overtemp_out_n,
    input wire logic       overtemp_out_n_oe
);
    logic [7:0] cfg_q;
    logic [2:0] rate_q;

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    // shadow of config and rate, written through either mirror
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cfg_q  <= RST_CONFIG;
            rate_q <= RST_RATE[2:0];
        end else if (reg_wr && (reg_addr == OFS_CONFIG || reg_addr == OFS_CONFIG_ALT)) begin
            cfg_q <= reg_wdata & MSK_CONFIG;
        end else if (reg_wr && (reg_addr == OFS_RATE || reg_addr == OFS_RATE_ALT)) begin
            rate_q <= reg_wdata[2:0];
        end
    end

    sequence rd_at(logic [7:0] a);
        reg_rd && reg_addr == a;
    endsequence

    sequence shot_wr;
        reg_wr && reg_addr == OFS_ONE_SHOT;
    endsequence

    pins_oe_a:
    assert property (alert_out_n_oe == !alert_out_n && overtemp_out_n_oe == !overtemp_out_n)
        else $error("pin enable disagrees with pin level");
    cfg_out_a:
    assert property ($stable(cfg_q) |-> series_r_correction_off == cfg_q[CFG_SERIES_OFF]
        && adaptive_averaging_off == cfg_q[CFG_AVG_OFF])
        else $error("config level outputs differ from config");
    rate_out_a:
    assert property ($stable(rate_q) |-> update_rate_code == rate_q)
        else $error("rate code differs from rate register");
    shot_temp_a:
    assert property (shot_wr ##0 cfg_q[CFG_TEMP_HALT] |=> temp_start)
        else $error("one-shot did not start temperature");
    shot_volt_a:
    assert property (shot_wr ##0 cfg_q[CFG_VOLT_HALT] |=> volt_start)
        else $error("one-shot did not start voltage");
    shot_read_a:
    assert property (rd_at(OFS_ONE_SHOT) |=> reg_rdata == READ_ZERO)
        else $error("one-shot read not zero");
    status_unused_a:
    assert property (rd_at(OFS_STATUS) or rd_at(OFS_STATUS_ALT)
        |=> reg_rdata[5] == 1'b0 && reg_rdata[0] == 1'b0)
        else $error("unused status bits not zero");
    live_bits_a:
    assert property (reg_rd && reg_addr == OFS_STATUS && $stable({conv_busy, spike_live})
        |=> reg_rdata[7:6] == $past({conv_busy, spike_live}))
        else $error("busy or peak bit wrong");
    fault_clear_a:
    assert property ((reg_rd && reg_addr == OFS_FAULT && !temp_done) [*2]
        |=> reg_rdata == READ_ZERO)
        else $error("fault register not cleared by read");
    mask_all_a:
    assert property (cfg_q[CFG_MASK_ALL] && !cfg_q[CFG_COMP_MODE]
        && $past(cfg_q[CFG_MASK_ALL] && !cfg_q[CFG_COMP_MODE]) |-> alert_out_n)
        else $error("alert driven while masked");
    volt_crit_a:
    assert property (volt_crit [*3] |-> !overtemp_out_n)
        else $error("voltage crit did not assert overtemp");
endmodule

bind mlsc_regs mlsc_check u_check (.*);

// file: sim/mlsc_host.sv
`timescale 1ns/1ps
module mlsc_host (
    // clock
    input  wire logic       clock,
    // register port toward the block
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    // one step per falling edge; strobes stand until the next step
    task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_wr    = w;
        reg_rd    = r;
        reg_addr  = a;
        reg_wdata = d;
    endtask
    // released address and data flip so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        op(1'b1, 1'b0, a, d);
        op(1'b0, 1'b0, ~a, ~d);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        op(1'b0, 1'b1, a, 8'h00);
        op(1'b0, 1'b0, ~a, 8'hff);
        d = reg_rdata;
    endtask
    // idle bus at time zero
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end
endmodule

// file: sim/mlsc_regs_tb.sv
`timescale 1ns/1ps
module mlsc_regs_tb;
    import mlsc_pkg::*;
    logic       clock = 1'b0;
    logic       rst_n = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, local_int, got;
    logic       reg_wr, reg_rd, conv_busy, spike_live, temp_done, remote_channel_fault, volt_high;
    logic       volt_done, volt_low, volt_crit, high_status_cleared, low_status_cleared;
    logic       temp_start, volt_start, series_r_correction_off, adaptive_averaging_off;
    logic [2:0] update_rate_code;
    logic       alert_out_n, alert_out_n_oe, overtemp_out_n, overtemp_out_n_oe;
    int         mismatches = 0;
    int         samples_checked = 0;
    int         starts = 0;
    // address and reset value, mirrors and an unmapped place included
    logic [15:0] rst_tab [22] = '{16'h0200, 16'h3400, 16'h0300, 16'h0900, 16'h0406,
        16'h0a06, 16'h0555, 16'h0b55, 16'h0680, 16'h0c80, 16'h0755, 16'h0d55, 16'h0880,
        16'h0e80, 16'h1300, 16'h1400, 16'h1964, 16'h1b00, 16'h2064, 16'h210a, 16'h0f00,
        16'h3000};
    // write address, read address, data, expected read
    logic [31:0] wr_tab [11] = '{32'h040aff07, 32'h0a040606, 32'h1313ffe0, 32'h1414ffe0,
        32'h2121ff7f, 32'h21210a0a, 32'h3030ff00, 32'h0309fff6, 32'h09030000,
        32'h0b055a5a, 32'h050b5555};

    mlsc_host host (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    mlsc_regs #(.TICK_LEN(4)) uut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .conv_busy(conv_busy), .spike_live(spike_live), .temp_done(temp_done),
        .local_int(local_int), .local_frac(8'h00), .remote_int(8'h00),
        .remote_frac(8'h00), .remote_channel_fault(remote_channel_fault),
        .volt_done(volt_done), .volt_high(volt_high), .volt_low(volt_low),
        .volt_crit(volt_crit), .high_status_cleared(high_status_cleared),
        .low_status_cleared(low_status_cleared), .temp_start(temp_start),
        .volt_start(volt_start), .series_r_correction_off(series_r_correction_off),
        .adaptive_averaging_off(adaptive_averaging_off),
        .update_rate_code(update_rate_code), .alert_out_n(alert_out_n),
        .alert_out_n_oe(alert_out_n_oe), .overtemp_out_n(overtemp_out_n),
        .overtemp_out_n_oe(overtemp_out_n_oe));

    // free-running 100 ns clock
    always #50 clock = ~clock;

    // count converter starts seen at the sampling edge
    always @(posedge clock) starts += temp_start + volt_start;

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, got);
        chk($sformatf("reg %h", a), exp, got);
    endtask
    // one conversion result, then time for status and pins to settle
    task automatic conv(input logic [7:0] t, input logic f);
        @(negedge clock);
        local_int = t;
        remote_channel_fault = f;
        temp_done = 1'b1;
        @(negedge clock);
        temp_done = 1'b0;
        repeat (3) @(negedge clock);
    endtask
    task automatic clr();
        @(negedge clock);
        high_status_cleared = 1'b1;
        low_status_cleared = 1'b1;
        @(negedge clock);
        high_status_cleared = 1'b0;
        low_status_cleared = 1'b0;
    endtask
    task automatic conclude();
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // hang guard, well beyond the few hundred cycles the sequence needs
    initial begin
        repeat (4000) @(posedge clock);
        mismatches++;
        conclude();
    end

    initial begin
        {conv_busy, spike_live, temp_done, remote_channel_fault, volt_high} = 5'h00;
        {volt_done, volt_low, volt_crit, high_status_cleared, low_status_cleared} = 5'h00;
        local_int = 8'h00;
        repeat (8) @(negedge clock);
        rst_n = 1'b1;
        starts = 0;
        repeat (40) @(negedge clock);
        chk("starts", 8'h08, 8'(starts));
        conv_busy = 1'b1;
        spike_live = 1'b1;
        rchk(OFS_STATUS, 8'hc0);
        chk("alert", 8'h01, {7'h00, alert_out_n & overtemp_out_n});
        conv_busy = 1'b0;
        spike_live = 1'b0;
        rchk(OFS_STATUS_ALT, 8'h00);
        foreach (rst_tab[i]) rchk(rst_tab[i][15:8], rst_tab[i][7:0]);
        foreach (wr_tab[i]) begin
            host.wr(wr_tab[i][31:24], wr_tab[i][15:8]);
            rchk(wr_tab[i][23:16], wr_tab[i][7:0]);
        end
        host.wr(OFS_CONFIG, 8'h44);
        @(negedge clock);
        starts = 0;
        repeat (40) @(negedge clock);
        chk("starts", 8'h00, 8'(starts));
        host.wr(OFS_ONE_SHOT, 8'h5a);
        @(negedge clock);
        chk("starts", 8'h02, 8'(starts));
        host.wr(OFS_CONFIG, 8'h00);
        conv(8'h55, 1'b0);
        rchk(OFS_STATUS, 8'h10);
        chk("alert", 8'h00, {7'h00, alert_out_n});
        clr();
        rchk(OFS_STATUS, 8'h00);
        conv(8'h80, 1'b0);
        rchk(OFS_STATUS, 8'h08);
        clr();
        {volt_high, volt_low} = 2'b11;
        volt_done = 1'b1;
        @(negedge clock);
        {volt_high, volt_low, volt_done} = 3'b000;
        rchk(OFS_STATUS, 8'h18);
        clr();
        // masked, then comparator mode which overrides the mask
        host.wr(OFS_CONFIG_ALT, 8'h80);
        conv(8'h55, 1'b0);
        rchk(OFS_STATUS, 8'h10);
        chk("alert", 8'h01, {7'h00, alert_out_n});
        host.wr(OFS_CONFIG, 8'ha0);
        repeat (2) @(negedge clock);
        chk("alert", 8'h00, {7'h00, alert_out_n});
        host.wr(OFS_CONFIG, 8'h80);
        conv(8'h64, 1'b0);
        chk("overtemp", 8'h00, {7'h00, overtemp_out_n});
        rchk(OFS_STATUS, 8'h12);
        conv(8'h5b, 1'b0);
        chk("overtemp", 8'h00, {7'h00, overtemp_out_n});
        conv(8'h59, 1'b0);
        chk("overtemp", 8'h01, {7'h00, overtemp_out_n});
        volt_crit = 1'b1;
        repeat (4) @(negedge clock);
        chk("overtemp", 8'h00, {7'h00, overtemp_out_n});
        volt_crit = 1'b0;
        host.wr(OFS_CONFIG, 8'h12);
        host.wr(OFS_RATE, 8'h03);
        chk("cfg", 8'h03, {6'h00, series_r_correction_off, adaptive_averaging_off});
        chk("rate", 8'h03, {5'h00, update_rate_code});
        clr();
        conv(8'h00, 1'b1);
        rchk(OFS_STATUS, 8'h04);
        host.op(1'b0, 1'b1, OFS_FAULT, 8'h00);
        host.op(1'b0, 1'b1, OFS_FAULT, 8'h00);
        chk("fault", 8'h02, reg_rdata);
        host.op(1'b0, 1'b0, 8'h00, 8'h00);
        chk("fault", 8'h00, reg_rdata);
        conclude();
    end
endmodule
